// [common/dcc_pkg.sv]
package dcc_pkg;
	// Register offsets on the plain register port
	localparam logic [3:0] OFF_CONTROL   = 4'h0;
	localparam logic [3:0] OFF_INT_STAT  = 4'h1;
	localparam logic [3:0] OFF_INT_MASK  = 4'h2;
	localparam logic [3:0] OFF_PIN_STATE = 4'h3;

	// Control register field positions
	localparam int POS_TWO_RESULT = 7;
	localparam int POS_ONE_RESULT = 6;
	localparam int POS_TWO_INVERT = 5;
	localparam int POS_ONE_INVERT = 4;
	localparam int POS_IN_SWITCH  = 3;
	localparam int POS_MODE_LSB   = 0;

	// Interrupt status bit positions
	localparam int POS_IRQ_CHANGE = 0;

	// Reset values
	localparam logic [7:0] RST_CONTROL  = 8'h00;
	localparam logic [7:0] RST_INT_MASK = 8'h00;

	// Mode in which the internal reference feeds both positive inputs
	localparam logic [2:0] MODE_INT_REF = 3'h6;

	// Input source selections per comparator input
	typedef enum logic [2:0]
	{
		DCC_SRC_NONE = 3'h0,
		DCC_SRC_PIN1 = 3'h1,
		DCC_SRC_PIN2 = 3'h2,
		DCC_SRC_PIN3 = 3'h3,
		DCC_SRC_PIN4 = 3'h4,
		DCC_SRC_PIN5 = 3'h5,
		DCC_SRC_PIN6 = 3'h6,
		DCC_SRC_VREF = 3'h7
	} dcc_src_t;

	// Routing of one comparator
	typedef struct packed
	{
		dcc_src_t pos;
		dcc_src_t neg;
	} dcc_route_t;

	// Control fields
	typedef struct packed
	{
		logic       two_invert;
		logic       one_invert;
		logic       in_switch;
		logic [2:0] mode;
	} dcc_ctrl_t;
endpackage

// [rtl/dcc_route.sv]
`timescale 1ns/1ps
// Input multiplexer map: mode and switch bit to pin selections
module dcc_route
(
	input  wire dcc_pkg::dcc_ctrl_t  ctrl,      // Control fields
	output dcc_pkg::dcc_route_t      route_one, // Comparator one inputs
	output dcc_pkg::dcc_route_t      route_two, // Comparator two inputs
	output logic                     out_pins   // Results driven to pins 1 and 2
);
	// Mode decode; mode 110 uses the reference and the switch bit
	always_comb
	begin
		route_one = '{dcc_pkg::DCC_SRC_NONE, dcc_pkg::DCC_SRC_NONE};
		route_two = '{dcc_pkg::DCC_SRC_NONE, dcc_pkg::DCC_SRC_NONE};
		out_pins  = 1'b0;
		case (ctrl.mode) // RULE_02
			3'h1, 3'h2, 3'h3, 3'h4, 3'h5:
			begin
				route_one = '{dcc_pkg::DCC_SRC_PIN5, dcc_pkg::DCC_SRC_PIN6};
				route_two = '{dcc_pkg::DCC_SRC_PIN3, dcc_pkg::DCC_SRC_PIN4};
				out_pins  = (ctrl.mode == 3'h5);
			end
			dcc_pkg::MODE_INT_REF:
			begin
				route_one.pos = dcc_pkg::DCC_SRC_VREF; // RULE_03 RULE_08
				route_two.pos = dcc_pkg::DCC_SRC_VREF;
				route_one.neg = ctrl.in_switch ? dcc_pkg::DCC_SRC_PIN5 : dcc_pkg::DCC_SRC_PIN6;
				route_two.neg = ctrl.in_switch ? dcc_pkg::DCC_SRC_PIN3 : dcc_pkg::DCC_SRC_PIN4;
				out_pins      = 1'b0;
			end
			default:
			begin
				route_one = '{dcc_pkg::DCC_SRC_NONE, dcc_pkg::DCC_SRC_NONE};
				route_two = '{dcc_pkg::DCC_SRC_NONE, dcc_pkg::DCC_SRC_NONE};
				out_pins  = 1'b0;
			end
		endcase
	end
endmodule

// [rtl/dcc_top.sv]
`timescale 1ns/1ps
// What this block does
// [RULE_01] Two independent comparator channels, each one digital result.
// [RULE_02] Inputs shared with pins one to six; mode picks the routing.
// [RULE_03] The internal reference may be chosen as a comparator input.
// [RULE_04] One control register drives input and output multiplexers.
// [RULE_05] Bit 7 reads channel two result, reset 0, inverted when selected.
// [RULE_06] Bit 6 reads channel one result, reset 0, inverted when selected.
// [RULE_07] Bits 5 and 4 invert channel two and one outputs.
// [RULE_08] Three-bit mode; mode 110 puts reference on both positive inputs.
// [RULE_09] Output change sets the flag; writing 0 clears, writing 1 sets.
module dcc_top
(
	input  wire logic                mclk,        // System clock
	input  wire logic                nrst,        // Async reset, active low
	input  wire logic                clk_en,      // Freezes all state when low
	input  wire logic                cmp_one_raw, // Analog comparator one, pos above neg
	input  wire logic                cmp_two_raw, // Analog comparator two, pos above neg
	input  wire logic [3:0]          reg_addr,    // Register address
	input  wire logic [7:0]          reg_wdata,   // Write data
	input  wire logic                reg_wr,      // Write strobe
	input  wire logic                reg_rd,      // Read strobe
	output logic [7:0]               reg_rdata,   // Read data, cycle after strobe
	output dcc_pkg::dcc_route_t      route_one,   // Comparator one input selects
	output dcc_pkg::dcc_route_t      route_two,   // Comparator two input selects
	output logic                     pin_out_en,  // Results routed to pins 1 and 2
	output logic                     pin1_out,    // Channel one result on pin
	output logic                     pin2_out,    // Channel two result on pin
	output logic                     irq          // Level interrupt
);
	logic [7:0]          ctrl_bits;
	logic                one_result;
	logic                two_result;
	logic                change_flag;
	logic                int_mask;
	dcc_pkg::dcc_ctrl_t  ctrl;
	dcc_pkg::dcc_route_t next_route_one;
	dcc_pkg::dcc_route_t next_route_two;
	logic                next_out_en;

	// Decoded strobes
	wire wr_ctrl = reg_wr && (reg_addr == dcc_pkg::OFF_CONTROL);
	wire wr_stat = reg_wr && (reg_addr == dcc_pkg::OFF_INT_STAT);
	wire wr_mask = reg_wr && (reg_addr == dcc_pkg::OFF_INT_MASK);

	// Polarity applied to the raw compare
	wire next_one = cmp_one_raw ^ ctrl.one_invert; // RULE_01 RULE_06 RULE_07
	wire next_two = cmp_two_raw ^ ctrl.two_invert; // RULE_05 RULE_07
	wire changed  = (next_one != one_result) || (next_two != two_result); // RULE_09

	// Next flag and mask, so the level interrupt never lags a clear or a mask write
	wire next_flag = changed ? 1'b1 : (wr_stat ? reg_wdata[dcc_pkg::POS_IRQ_CHANGE] : change_flag); // RULE_09
	wire next_mask = wr_mask ? reg_wdata[0] : int_mask;

	// Writable control fields
	assign ctrl = dcc_ctrl_t_of(ctrl_bits);

	function automatic dcc_pkg::dcc_ctrl_t dcc_ctrl_t_of(input logic [7:0] v);
		dcc_ctrl_t_of.two_invert = v[dcc_pkg::POS_TWO_INVERT];
		dcc_ctrl_t_of.one_invert = v[dcc_pkg::POS_ONE_INVERT];
		dcc_ctrl_t_of.in_switch  = v[dcc_pkg::POS_IN_SWITCH];
		dcc_ctrl_t_of.mode       = v[dcc_pkg::POS_MODE_LSB +: 3];
	endfunction

	// Read mux; result bits sit above the control fields
	wire [7:0] ctrl_read = {two_result, one_result, ctrl_bits[5:0]}; // RULE_05 RULE_06
	wire [7:0] rd_mux    =
		(reg_addr == dcc_pkg::OFF_CONTROL)  ? ctrl_read :
		(reg_addr == dcc_pkg::OFF_INT_STAT) ? {7'h00, change_flag} :
		(reg_addr == dcc_pkg::OFF_INT_MASK) ? {7'h00, int_mask} :
		(reg_addr == dcc_pkg::OFF_PIN_STATE) ? {6'h00, cmp_two_raw, cmp_one_raw} : 8'h00;

	// Mux map shared with the routing module
	dcc_route u_route
	(
		.ctrl      (ctrl),
		.route_one (next_route_one),
		.route_two (next_route_two),
		.out_pins  (next_out_en)
	);

	// Control register; top bits are read-only and never stored
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			ctrl_bits <= dcc_pkg::RST_CONTROL;
		else if (clk_en && wr_ctrl)
			ctrl_bits <= {2'h0, reg_wdata[5:0]}; // RULE_04
	end

	// Result bits registered so a change can be seen
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			one_result <= 1'b0;
			two_result <= 1'b0;
		end
		else if (clk_en)
		begin
			one_result <= next_one;
			two_result <= next_two;
		end
	end

	// Change flag: hardware set wins over software clear
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			change_flag <= 1'b0;
		else if (clk_en)
		begin
			if (changed)
				change_flag <= 1'b1; // RULE_09
			else if (wr_stat)
				change_flag <= reg_wdata[dcc_pkg::POS_IRQ_CHANGE]; // RULE_09
		end
	end

	// Mask register
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			int_mask <= dcc_pkg::RST_INT_MASK[0];
		else if (clk_en && wr_mask)
			int_mask <= reg_wdata[0];
	end

	// Registered outputs; pin state address is read-only
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_rdata  <= 8'h00;
			route_one  <= '{dcc_pkg::DCC_SRC_NONE, dcc_pkg::DCC_SRC_NONE};
			route_two  <= '{dcc_pkg::DCC_SRC_NONE, dcc_pkg::DCC_SRC_NONE};
			pin_out_en <= 1'b0;
			pin1_out   <= 1'b0;
			pin2_out   <= 1'b0;
			irq        <= 1'b0;
		end
		else if (clk_en)
		begin
			reg_rdata  <= reg_rd ? rd_mux : 8'h00;
			route_one  <= next_route_one; // RULE_02 RULE_04
			route_two  <= next_route_two;
			pin_out_en <= next_out_en;
			pin1_out   <= next_one;
			pin2_out   <= next_two;
			irq        <= next_flag && next_mask; // RULE_09
		end
	end

	// Checks
	sequence s_flip;
		clk_en && changed;
	endsequence

	property p_change_sets;
		@(posedge mclk) disable iff (!nrst) s_flip |=> change_flag;
	endproperty
	a_change_sets: assert property (p_change_sets) else $error("change flag not set"); // RULE_09

	property p_clear;
		@(posedge mclk) disable iff (!nrst)
			clk_en && wr_stat && !reg_wdata[0] && !changed |=> !change_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared"); // RULE_09

	property p_bit7;
		@(posedge mclk) disable iff (!nrst)
			clk_en |=> two_result == ($past(cmp_two_raw) ^ $past(ctrl.two_invert));
	endproperty
	a_bit7: assert property (p_bit7) else $error("channel two result wrong"); // RULE_05

	property p_bit6;
		@(posedge mclk) disable iff (!nrst)
			clk_en |=> one_result == ($past(cmp_one_raw) ^ $past(ctrl.one_invert));
	endproperty
	a_bit6: assert property (p_bit6) else $error("channel one result wrong"); // RULE_06

	property p_read;
		@(posedge mclk) disable iff (!nrst)
			clk_en && reg_rd && reg_addr == dcc_pkg::OFF_CONTROL |=> reg_rdata[7:6] == $past({two_result, one_result});
	endproperty
	a_read: assert property (p_read) else $error("result bits not readable"); // RULE_05

	property p_irq;
		@(posedge mclk) disable iff (!nrst)
			clk_en |=> irq == (change_flag && int_mask);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong"); // RULE_09

	property p_ref;
		@(posedge mclk) disable iff (!nrst)
			clk_en && ctrl.mode == dcc_pkg::MODE_INT_REF |=> route_one.pos == dcc_pkg::DCC_SRC_VREF
				&& route_two.pos == dcc_pkg::DCC_SRC_VREF;
	endproperty
	a_ref: assert property (p_ref) else $error("reference not routed"); // RULE_08

	property p_ctrl_wr;
		@(posedge mclk) disable iff (!nrst)
			clk_en && wr_ctrl ##1 clk_en |=> route_one == $past(next_route_one);
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("routing not from control"); // RULE_04

	property p_pins;
		@(posedge mclk) disable iff (!nrst)
			clk_en && ctrl.mode == 3'h0 |=> route_two.neg == dcc_pkg::DCC_SRC_NONE;
	endproperty
	a_pins: assert property (p_pins) else $error("mode 0 not off"); // RULE_02
endmodule

// [tb/dcc_analog.sv]
`timescale 1ns/1ps
// Far side: the analog comparators, seen as clean levels
module dcc_analog
(
	input  wire logic                mclk,        // System clock
	input  wire dcc_pkg::dcc_route_t route_one,   // Channel one selects
	input  wire dcc_pkg::dcc_route_t route_two,   // Channel two selects
	input  wire logic                lvl_one,     // Wanted level, channel one
	input  wire logic                lvl_two,     // Wanted level, channel two
	output logic                     cmp_one_raw, // Channel one compare
	output logic                     cmp_two_raw  // Channel two compare
);
	initial cmp_one_raw = 1'b0;
	initial cmp_two_raw = 1'b0;
	// An unrouted channel reads low; changes land just after the edge
	always @(posedge mclk)
	begin
		cmp_one_raw <= lvl_one & (route_one.pos != dcc_pkg::DCC_SRC_NONE);
		cmp_two_raw <= lvl_two & (route_two.pos != dcc_pkg::DCC_SRC_NONE);
	end
endmodule

// [tb/tb_dual_comparator_control.sv]
`timescale 1ns/1ps
// Register, routing and change-flag checks
module tb_dual_comparator_control;
	logic                mclk;
	logic                nrst;
	logic                clk_en;
	logic [3:0]          reg_addr;
	logic [7:0]          reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [7:0]          reg_rdata;
	dcc_pkg::dcc_route_t route_one;
	dcc_pkg::dcc_route_t route_two;
	dcc_pkg::dcc_src_t   s;
	logic                pin_out_en;
	logic                pin1_out;
	logic                pin2_out;
	logic                irq;
	logic                cmp_one_raw;
	logic                cmp_two_raw;
	logic                lvl_one;
	logic                lvl_two;
	logic [7:0]          got;
	logic [7:0]          w;
	int                  fail_count;
	int                  n_compared;
	int                  m;

	dcc_top i_dut (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .cmp_one_raw(cmp_one_raw),
		.cmp_two_raw(cmp_two_raw), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .route_one(route_one), .route_two(route_two),
		.pin_out_en(pin_out_en), .pin1_out(pin1_out), .pin2_out(pin2_out), .irq(irq));
	dcc_analog i_far (.mclk(mclk), .route_one(route_one), .route_two(route_two), .lvl_one(lvl_one),
		.lvl_two(lvl_two), .cmp_one_raw(cmp_one_raw), .cmp_two_raw(cmp_two_raw));

	always #50 mclk = ~mclk;

	// Strobes last one cycle; read data sampled once the taking edge has landed
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 got = reg_rdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic lv(input logic a, input logic b);
		@(posedge mclk);
		lvl_one <= a;
		lvl_two <= b;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %0t reg %h want %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %0t flag %b want %b", $time, g, e);
		end
	endtask
	task automatic summarize();
		if (fail_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Routed channels follow the wanted level; modes 000 and 111 leave them low
	function automatic logic [1:0] raw_exp(input logic [2:0] mode, input logic l1, input logic l2);
		logic on;
		on = (mode != 3'h0) && (mode != 3'h7);
		return {l2 & on, l1 & on};
	endfunction
	// Readback: live results with inversion, written bits 7:6 ignored
	function automatic logic [7:0] ctrl_exp(input logic [7:0] v, input logic l1, input logic l2);
		logic [1:0] r;
		r = raw_exp(v[2:0], l1, l2);
		return {r[1] ^ v[5], r[0] ^ v[4], v[5:0]};
	endfunction

	// Generous bound: the sequence needs well under a tenth of it
	initial
	begin
		#300000;
		fail_count++;
		summarize();
	end

	initial
	begin
		mclk = 1'b0;
		nrst = 1'b0;
		clk_en = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		lvl_one = 1'b0;
		lvl_two = 1'b0;
		fail_count = 0;
		n_compared = 0;
		m = $urandom(32'hf785);
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		rd(dcc_pkg::OFF_CONTROL);
		chk8(got, dcc_pkg::RST_CONTROL);
		rd(dcc_pkg::OFF_INT_MASK);
		chk8(got, dcc_pkg::RST_INT_MASK);
		rd(4'hf);
		chk8(got, 8'h00);
		// Random words and levels; bits 7:6 of the write are noise
		repeat (12)
		begin
			w = 8'($urandom);
			lv(1'($urandom), 1'($urandom));
			wr(dcc_pkg::OFF_CONTROL, w);
			idle(4);
			rd(dcc_pkg::OFF_CONTROL);
			chk8(got, ctrl_exp(w, lvl_one, lvl_two));
			rd(dcc_pkg::OFF_PIN_STATE);
			chk8(got, {6'h00, raw_exp(w[2:0], lvl_one, lvl_two)});
		end
		// Every mode: pin drive only in 101, reference only in 110
		lv(1'b1, 1'b0);
		for (int k = 0; k < 8; k++)
		begin
			wr(dcc_pkg::OFF_CONTROL, {5'h00, 3'(k)});
			idle(4);
			chk1(pin_out_en, k == 5);
			chk1(route_one.pos === dcc_pkg::DCC_SRC_VREF, k == 6);
			chk1(route_two.pos === dcc_pkg::DCC_SRC_VREF, k == 6);
			if (k >= 1 && k <= 5)
				chk1(3'(route_one.neg) inside {[3'h1:3'h6]}, 1'b1);
			if (k == 5)
			begin
				chk1(pin1_out, 1'b1);
				chk1(pin2_out, 1'b0);
			end
			if (k == 6)
				s = route_one.neg;
		end
		wr(dcc_pkg::OFF_CONTROL, 8'h0e);
		idle(2);
		chk1(route_one.neg !== s, 1'b1);
		chk1(route_one.neg === dcc_pkg::DCC_SRC_PIN5, 1'b1);
		chk1(route_two.neg === dcc_pkg::DCC_SRC_PIN3, 1'b1);
		// Change flag: hardware set, cleared by zero, masked, set by a one
		wr(dcc_pkg::OFF_CONTROL, 8'h03);
		wr(dcc_pkg::OFF_INT_MASK, 8'h01);
		idle(4);
		wr(dcc_pkg::OFF_INT_STAT, 8'h00);
		idle(1);
		chk1(irq, 1'b0);
		lv(1'b0, 1'b0);
		idle(4);
		chk1(irq, 1'b1);
		rd(dcc_pkg::OFF_INT_STAT);
		chk8(got, 8'h01);
		wr(dcc_pkg::OFF_INT_MASK, 8'h00);
		idle(1);
		chk1(irq, 1'b0);
		wr(dcc_pkg::OFF_INT_STAT, 8'h00);
		wr(dcc_pkg::OFF_INT_MASK, 8'h01);
		idle(1);
		chk1(irq, 1'b0);
		wr(dcc_pkg::OFF_INT_STAT, 8'h01);
		idle(1);
		chk1(irq, 1'b1);
		// Clock enable low: a level change must not reach the result
		@(posedge mclk);
		clk_en <= 1'b0;
		lv(1'b1, 1'b1);
		idle(4);
		chk1(pin1_out, 1'b0);
		@(posedge mclk);
		clk_en <= 1'b1;
		idle(2);
		chk1(pin1_out, 1'b1);
		summarize();
	end
endmodule
